// file: pcs_core.v
// Summary of operation
// - 13-bit program counter; low byte readable and writable.
// - upper five bits loaded from the high latch, the stack or the vector, never directly.
// - every reset clears the whole program counter.
// - low byte write copies latch bits 4..0 into upper bits.
// - call and goto take top two bits from latch bits 4..3.
// - low byte destination replaces upper bits in the same step.
// - eight-entry, 13-bit return stack outside program and data space.
// - stack pointer not visible to software.
// - push on call or interrupt vectoring.
// - pop into program counter on return, literal return, interrupt return.
// - push and pop leave the high latch unchanged.
// - stack wraps circularly; ninth push overwrites the first entry.
// - no overflow or underflow status anywhere.
// - indirect port accesses the location held in the file pointer.
// - indirect read through the port itself returns zero.
// - indirect write to the port itself changes no data.
// - effective address is bank bit above 8-bit file pointer.
`include "pcs_consts.vh"
module pcs_core
(
   input wire sys_clk,
   input wire nrst,
   input wire exec_en,
   input wire do_call,
   input wire do_goto,
   input wire do_return,
   input wire int_vector,
   input wire [`PCS_PC_W-1:0] vector_addr,
   input wire [`PCS_JMP_W-1:0] jump_operand,
   input wire pc_low_write,
   input wire [`PCS_LOW_W-1:0] pc_low_wdata,
   input wire [`PCS_LOW_W-1:0] pc_high_latch,
   input wire [`PCS_LOW_W-1:0] file_pointer,
   input wire indirect_bank_bit,
   input wire [`PCS_LOW_W-1:0] file_addr,
   input wire file_rd,
   input wire file_wr,
   input wire [`PCS_LOW_W-1:0] file_wdata,
   input wire [`PCS_LOW_W-1:0] ram_rdata,
   output wire [`PCS_PC_W-1:0] pc,
   output wire [`PCS_LOW_W-1:0] pc_low_byte,
   output wire [`PCS_EA_W-1:0] ram_addr,
   output wire ram_rd,
   output wire ram_wr,
   output wire [`PCS_LOW_W-1:0] ram_wdata,
   output wire [`PCS_LOW_W-1:0] file_rdata
);

// ----------------------------------------
// program counter and stack state
// ----------------------------------------
// one-hot action codes, one per kind of step
localparam [5:0] ACT_HOLD = 6'h01;
localparam [5:0] ACT_INC = 6'h02;
localparam [5:0] ACT_LOW = 6'h04;
localparam [5:0] ACT_RET = 6'h08;
localparam [5:0] ACT_JUMP = 6'h10;
localparam [5:0] ACT_INT = 6'h20;

reg [`PCS_PC_W-1:0] pc_q;
reg [`PCS_PC_W-1:0] pc_d;
reg [`PCS_SP_W-1:0] sp_q;
reg [`PCS_SP_W-1:0] sp_d;
reg [`PCS_PC_W-1:0] stack_mem [0:`PCS_STK_DEPTH-1];
reg [`PCS_PC_W-1:0] push_val;
wire [5:0] act;
wire [`PCS_PC_W-1:0] pc_inc;
wire [`PCS_SP_W-1:0] sp_prev;
wire [`PCS_SP_W-1:0] sp_next;
wire push_en;
wire pop_en;
integer i;

function [`PCS_SP_W-1:0] sp_step;
   input [`PCS_SP_W-1:0] sp;
   input up;
   begin
      // natural wrap of a 3-bit pointer gives the circular stack
      if (up)
      begin
         sp_step = sp + 3'h1;
      end
      else
      begin
         sp_step = sp - 3'h1;
      end
   end
endfunction

function [5:0] act_decode;
   input exec;
   input intv;
   input jump;
   input ret;
   input low;
   begin
      // priority: interrupt, call or goto, return, low byte write
      if (!exec)
      begin
         act_decode = ACT_HOLD;
      end
      else if (intv)
      begin
         act_decode = ACT_INT;
      end
      else if (jump)
      begin
         act_decode = ACT_JUMP;
      end
      else if (ret)
      begin
         act_decode = ACT_RET;
      end
      else if (low)
      begin
         act_decode = ACT_LOW;
      end
      else
      begin
         act_decode = ACT_INC;
      end
   end
endfunction

function [`PCS_PC_W-1:0] pc_load;
   input [`PCS_LOW_W-1:0] latch;
   input [`PCS_JMP_W-1:0] low;
   input full;
   begin
      // a low byte write takes five latch bits, call and goto only two
      if (full)
      begin
         pc_load = {latch[`PCS_LATCH_UP_MSB:0], low[`PCS_LOW_W-1:0]};
      end
      else
      begin
         pc_load = {latch[`PCS_LATCH_UP_MSB:`PCS_LATCH_JMP_LSB], low};
      end
   end
endfunction

function addr_is_port;
   input [`PCS_LOW_W-1:0] addr;
   begin
      addr_is_port = (addr == `PCS_INDIRECT_ADDR);
   end
endfunction

assign pc_inc = pc_q + 13'h0001;
assign sp_prev = sp_step(sp_q, 1'b0);
assign sp_next = sp_step(sp_q, 1'b1);
assign act = act_decode(exec_en, int_vector, do_call | do_goto, do_return, pc_low_write);
assign push_en = (act == ACT_INT) | ((act == ACT_JUMP) & do_call);
assign pop_en = (act == ACT_RET);

// ----------------------------------------
// next program counter
// ----------------------------------------
always @*
begin
   pc_d = pc_q;
   sp_d = sp_q;
   case (act)
      ACT_INT:
      begin
         pc_d = vector_addr;
      end
      ACT_JUMP:
      begin
         pc_d = pc_load(pc_high_latch, jump_operand, 1'b0);
      end
      ACT_RET:
      begin
         pc_d = stack_mem[sp_prev];
      end
      ACT_LOW:
      begin
         pc_d = pc_load(pc_high_latch, {3'h0, pc_low_wdata}, 1'b1);
      end
      ACT_INC:
      begin
         pc_d = pc_inc;
      end
      default:
      begin
         // no instruction this cycle: hold
         pc_d = pc_q;
      end
   endcase
   if (push_en)
   begin
      sp_d = sp_next;
   end
   else if (pop_en)
   begin
      sp_d = sp_prev;
   end
end

always @(posedge sys_clk)
begin
   if (!nrst)
   begin
      pc_q <= `PCS_PC_RST;
      sp_q <= `PCS_SP_RST;
   end
   else
   begin
      pc_q <= pc_d;
      sp_q <= sp_d;
   end
end

// an interrupt resumes the current instruction, a call the next one
always @*
begin
   if (act == ACT_INT)
   begin
      push_val = pc_q;
   end
   else
   begin
      push_val = pc_inc;
   end
end

// ----------------------------------------
// return stack
// ----------------------------------------
// eight by thirteen storage
always @(posedge sys_clk)
begin
   if (!nrst)
   begin
      for (i = 0; i < `PCS_STK_DEPTH; i = i + 1)
      begin
         stack_mem[i] <= `PCS_PC_RST;
      end
   end
   else if (push_en)
   begin
      // return address is push_val: the next instruction for a call, the current one for an interrupt
      stack_mem[sp_q] <= push_val;
   end
end

// upper bits only via pc output
assign pc = pc_q;
assign pc_low_byte = pc_q[`PCS_LOW_W-1:0];

// ----------------------------------------
// indirect addressing
// ----------------------------------------
wire is_ind;
wire self_ref;
reg [`PCS_EA_W-1:0] ea_r;
reg wr_r;
reg rd_r;
reg [`PCS_LOW_W-1:0] rdata_r;
assign is_ind = addr_is_port(file_addr);
assign self_ref = is_ind & addr_is_port(file_pointer);

always @*
begin
   // bank bit also heads direct addresses, a simplified bank map
   ea_r = {indirect_bank_bit, file_addr};
   wr_r = file_wr;
   rd_r = file_rd;
   rdata_r = ram_rdata;
   if (is_ind)
   begin
      ea_r = {indirect_bank_bit, file_pointer};
   end
   if (self_ref)
   begin
      wr_r = 1'b0;
      rd_r = 1'b0;
      rdata_r = `PCS_ZERO_BYTE;
   end
end

assign ram_addr = ea_r;
assign ram_wr = wr_r;
assign ram_rd = rd_r;
assign ram_wdata = file_wdata;
assign file_rdata = rdata_r;

endmodule

// file: pcs_consts.vh
`ifndef PCS_CONSTS_VH
`define PCS_CONSTS_VH
// ----------------------------------------
// widths and depths
// ----------------------------------------
`define PCS_PC_W 13
`define PCS_LOW_W 8
`define PCS_UP_W 5
`define PCS_JMP_W 11
`define PCS_STK_DEPTH 8
`define PCS_SP_W 3
`define PCS_EA_W 9
// ----------------------------------------
// reset values and field positions
// ----------------------------------------
`define PCS_PC_RST 13'h0000
`define PCS_SP_RST 3'h0
`define PCS_LATCH_UP_MSB 4
`define PCS_LATCH_JMP_LSB 3
// ----------------------------------------
// indirect port address and zero read
// ----------------------------------------
`define PCS_INDIRECT_ADDR 8'h00
`define PCS_ZERO_BYTE 8'h00
`endif

// file: pcs_core_assertions.sv
// ----------------------------------------
// pc flow and indirect port checks
// ----------------------------------------
module pcs_chk
(
   input wire sys_clk,
   input wire nrst,
   input wire exec_en,
   input wire do_call,
   input wire do_goto,
   input wire do_return,
   input wire int_vector,
   input wire pc_low_write,
   input wire [7:0] pc_low_wdata,
   input wire [7:0] pc_high_latch,
   input wire [10:0] jump_operand,
   input wire [7:0] file_pointer,
   input wire indirect_bank_bit,
   input wire [7:0] file_addr,
   input wire [12:0] pc,
   input wire [8:0] ram_addr,
   input wire ram_wr,
   input wire [7:0] file_rdata
);
   wire nop = ~(do_call | do_goto | do_return | int_vector);
   wire self = file_addr == 8'h00 && file_pointer == 8'h00;
   wire [4:0] lat5 = pc_high_latch[4:0];
   wire [1:0] lat2 = pc_high_latch[4:3];
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   sequence s_call; exec_en && do_call && !int_vector; endsequence
   sequence s_ret; exec_en && do_return && nop == 1'b0 && !do_call && !do_goto && !int_vector; endsequence
   property p_rst; $rose(nrst) |-> pc == 13'h0000; endproperty
   property p_low; exec_en && nop && pc_low_write |=> pc == {$past(lat5), $past(pc_low_wdata)}; endproperty
   property p_jmp; exec_en && do_goto && !int_vector |=> pc == {$past(lat2), $past(jump_operand)}; endproperty
   property p_inc; exec_en && nop && !pc_low_write |=> pc == $past(pc) + 13'h0001; endproperty
   property p_ret; s_call ##1 s_ret |=> pc == $past(pc, 2) + 13'h0001; endproperty
   property p_ea; file_addr == 8'h00 && file_pointer != 8'h00 |-> ram_addr == {indirect_bank_bit, file_pointer}; endproperty
   property p_rd0; self |-> file_rdata == 8'h00; endproperty
   property p_wr0; self |-> !ram_wr; endproperty
   property p_hold; !exec_en |=> $stable(pc); endproperty
   a_rst: assert property (p_rst) else $error("pc not cleared");
   a_low: assert property (p_low) else $error("low write load");
   a_jmp: assert property (p_jmp) else $error("goto load");
   a_inc: assert property (p_inc) else $error("no increment");
   a_ret: assert property (p_ret) else $error("bad return");
   a_ea: assert property (p_ea) else $error("bad address");
   a_rd0: assert property (p_rd0) else $error("self read");
   a_wr0: assert property (p_wr0) else $error("self write");
   a_hold: assert property (p_hold) else $error("pc moved without execute");
endmodule
bind pcs_core pcs_chk i_pcs_chk (.*);

// file: test_pcs_core.sv
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
$display("ERROR %s exp %h got %h", n, e, g); end end
module test_pcs_core;
   timeunit 1ns;
   timeprecision 1ns;
   // ----------------------------------------
   // stimulus and checks
   // ----------------------------------------
   logic sys_clk = 0, nrst = 0, exec_en = 0, do_call = 0, do_goto = 0, do_return = 0;
   logic int_vector = 0, pc_low_write = 0, indirect_bank_bit = 0, file_rd = 0, file_wr = 0;
   logic [12:0] vector_addr = 13'h0000;
   logic [10:0] jump_operand = 11'h000;
   logic [7:0] pc_low_wdata = 8'h00, pc_high_latch = 8'h00, file_pointer = 8'h00;
   logic [7:0] file_addr = 8'h00, file_wdata = 8'h00, ram_rdata = 8'h00;
   wire [12:0] pc;
   wire [7:0] pc_low_byte, ram_wdata, file_rdata;
   wire [8:0] ram_addr;
   wire ram_rd, ram_wr;
   int n_errors = 0, num_checks = 0;
   pcs_core i_pcs_core (.*);
   initial forever #50 sys_clk = ~sys_clk;
   task stop_test;
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // exec stays high so back-to-back steps never toggle it twice
   task ex(input [4:0] k, input [10:0] op);
      {do_call, do_goto, do_return, int_vector, pc_low_write} = k;
      exec_en = 1'b1;
      jump_operand = op;
      pc_low_wdata = op[7:0];
      @(posedge sys_clk);
      #1;
   endtask
   task t_flow;
      pc_high_latch = 8'hf5;
      ex(5'h01, 11'h03c);
      `CHK("pc low", 13'h153c, pc)
      `CHK("low byte", 8'h3c, pc_low_byte)
      ex(5'h00, 11'h000);
      `CHK("pc inc", 13'h153d, pc)
      pc_high_latch = 8'h18;
      ex(5'h08, 11'h123);
      `CHK("pc goto", 13'h1923, pc)
      vector_addr = 13'h0004;
      ex(5'h02, 11'h000);
      `CHK("pc int", 13'h0004, pc)
      ex(5'h04, 11'h000);
      `CHK("pc reti", 13'h1923, pc)
      pc_high_latch = 8'h02;
      ex(5'h01, 11'h0fe);
      ex(5'h01, 11'h004);
      `CHK("no carry", 13'h0204, pc)
      pc_high_latch = 8'h03;
      ex(5'h01, 11'h004);
      `CHK("latch step", 13'h0304, pc)
      $display("flow done");
   endtask
   task t_stack;
      int i;
      pc_high_latch = 8'h00;
      ex(5'h01, 11'h0ff);
      for (i = 0; i < 9; i++)
         ex(5'h10, 11'(i + 256));
      for (i = 0; i < 9; i++)
      begin
         ex(5'h04, 11'h000);
         `CHK("pop", (i == 8) ? 13'h108 : 13'(264 - i), pc)
      end
      exec_en = 1'b0;
      $display("stack done");
   endtask
   task t_rst;
      nrst = 1'b0;
      @(posedge sys_clk);
      #1;
      nrst = 1'b1;
      `CHK("pc mid rst", 13'h0000, pc)
      ex(5'h10, 11'h055);
      ex(5'h04, 11'h000);
      `CHK("ret", 13'h0001, pc)
      ex(5'h04, 11'h000);
      `CHK("excess pop", 13'h0000, pc)
      exec_en = 1'b0;
      $display("reset done");
   endtask
   task t_ind;
      {file_rd, file_wr, indirect_bank_bit, file_pointer, ram_rdata} = {3'b111, 16'h475a};
      file_wdata = 8'hc3;
      #1;
      `CHK("ea", 9'h147, ram_addr)
      `CHK("rd en", 1'b1, ram_rd)
      `CHK("wdata", 8'hc3, ram_wdata)
      `CHK("wr", 1'b1, ram_wr)
      `CHK("rd", 8'h5a, file_rdata)
      @(posedge sys_clk);
      #1;
      file_pointer = 8'h00;
      #1;
      `CHK("self wr", 1'b0, ram_wr)
      `CHK("self rd", 8'h00, file_rdata)
      `CHK("self rd en", 1'b0, ram_rd)
      @(posedge sys_clk);
      #1;
      file_addr = 8'h35;
      #1;
      `CHK("direct ea", 9'h135, ram_addr)
      `CHK("direct wr", 1'b1, ram_wr)
      `CHK("direct rd", 8'h5a, file_rdata)
      $display("indirect done");
   endtask
   initial
   begin
      repeat (5) @(posedge sys_clk);
      #1;
      nrst = 1'b1;
      `CHK("pc rst", 13'h0000, pc)
      t_flow;
      t_stack;
      t_rst;
      t_ind;
      stop_test;
   end
   initial
   begin
      #20000;
      n_errors++;
      stop_test;
   end
endmodule
